// ==== src/fwuc_pkg.sv ====
// Constants, states and LRU helpers for the four-way unified cache.
// Assumes a single pclk domain and an APB register slave in the top.
// Summary of operation
// - Size field bits 16:14, resets to 001
// - Reserved size register bits read zero
// - Enabled cache looks up P0, P1, P3
// - Set index from address bits 9:4
// - Hit needs tag match and valid
// - Read hit returns data, touches LRU
// - Read miss refills line, forwards word
// - Refill sets valid, sets dirty only for a write miss, touches LRU
// - Dirty victim buffered, refill, then drain
// - Write-back hit: cache only, set dirty
// - Write-through hit: cache and memory
// - Write-back miss allocates and merges data
// - Write-through miss writes memory only
// - One-line buffer, refill before drain
// - Array windows: longword only, no fetch
// - Way field selects way 0 to 3
// - Tag read returns fields, no compare
// - Direct tag write stores all fields
// - Associative write updates dirty/valid on hit
// - Victim way decoded from LRU bits
// - Write policy from copyback/writethrough bits
// - Invalidate-all clears state, reads zero
// - Reset clears valid, dirty and LRU
package fwuc_pkg;
  // ************************************************
  // Register map and fields
  // ************************************************
  localparam logic [11:0] FWUC_CTRL_OFF = 12'h000;
  localparam logic [11:0] FWUC_SIZE_OFF = 12'h004;
  localparam logic [11:0] FWUC_STAT_OFF = 12'h008;
  localparam int FWUC_EN_BIT = 0;
  localparam int FWUC_WT_BIT = 1;
  localparam int FWUC_CB_BIT = 2;
  localparam int FWUC_FLUSH_BIT = 3;
  localparam int FWUC_SIZE_LSB = 14;
  localparam int FWUC_SIZE_MSB = 16;
  localparam logic [2:0] FWUC_SIZE_RST = 3'b001;
  localparam logic [2:0] FWUC_SIZE_16K = 3'b100;

  // ************************************************
  // Address and tag word fields
  // ************************************************
  localparam int FWUC_TAG_MSB = 28;
  localparam int FWUC_TAG_LSB = 10;
  localparam int FWUC_IDX_MSB = 9;
  localparam int FWUC_IDX_LSB = 4;
  localparam int FWUC_WORD_MSB = 3;
  localparam int FWUC_WORD_LSB = 2;
  localparam int FWUC_WAY_MSB = 11;
  localparam int FWUC_WAY_LSB = 10;
  localparam int FWUC_ASSOC_BIT = 3;
  localparam int FWUC_MM_SEL_BIT = 24;
  localparam int FWUC_DTY_BIT = 1;
  localparam int FWUC_VAL_BIT = 0;
  localparam logic [6:0] FWUC_MM_WIN = 7'h78;
  localparam logic [2:0] FWUC_P1 = 3'b100;
  localparam logic [2:0] FWUC_P3 = 3'b110;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_FILL = 2'b01,
    S_EXT = 2'b10
  } fwuc_state_t;

  // ************************************************
  // LRU helpers, pairwise order bits 01,02,03,12,13,23
  // ************************************************
  // Mark way w most recent
  function automatic logic [5:0] fwuc_lru_touch(input logic [1:0] w, input logic [5:0] o);
    logic [5:0] n;
    n = o;
    unique case (w)
      2'd0: n[5:3] = 3'b000;
      2'd1: begin
        n[5] = 1'b1;
        n[2:1] = 2'b00;
      end
      2'd2: begin
        n[4] = 1'b1;
        n[2] = 1'b1;
        n[0] = 1'b0;
      end
      2'd3: begin
        n[3] = 1'b1;
        n[1:0] = 2'b11;
      end
    endcase
    return n;
  endfunction

  // Way to replace
  function automatic logic [1:0] fwuc_lru_victim(input logic [5:0] l);
    if (l[5] && l[4] && l[3]) begin
      return 2'd0;
    end else if (!l[5] && l[2] && l[1]) begin
      return 2'd1;
    end else if (!l[4] && !l[2] && l[0]) begin
      return 2'd2;
    end
    return 2'd3;
  endfunction
endpackage

// ==== src/fwuc_cache.sv ====
// Four-way set-associative unified cache, 64 sets of 16-byte lines.
// Assumes CPU and bus handshakes are level requests held until a one-cycle ack.
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module fwuc_cache import fwuc_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cpu_req,
  input wire logic cpu_we,
  input wire logic cpu_fetch,
  input wire logic [31:0] cpu_addr,
  input wire logic [31:0] cpu_wdata,
  output logic cpu_ack,
  output logic cpu_err,
  output logic [31:0] cpu_rdata,
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata
);
  // ************************************************
  // Storage
  // ************************************************
  logic [18:0] tag_r [0:255];
  logic [31:0] dat_r [0:1023];
  logic [255:0] val_r;
  logic [255:0] dty_r;
  logic [5:0] lru_r [0:63];
  logic [31:0] wbd_r [0:3];
  logic [31:0] wb_addr_r;
  logic wb_valid_r;
  logic [1:0] wcnt_r;

  fwuc_state_t st_r;
  logic [31:0] rq_addr_r;
  logic rq_we_r;
  logic [31:0] rq_wdata_r;
  logic [1:0] f_way_r;
  logic [1:0] fcnt_r;
  logic own_drn_r;
  logic en_r;
  logic wt_r;
  logic cb_r;
  logic [2:0] size_r;

  // ************************************************
  // Lookup
  // ************************************************
  logic [5:0] set;
  logic [1:0] wd;
  logic is_mm;
  logic is_tagw;
  logic mm_ok;
  logic cach;
  logic wback;
  logic [18:0] cmp_tag;
  logic [3:0] hit_raw;
  logic [3:0] hits;
  logic hit;
  logic [1:0] hway;
  logic [1:0] rway;
  logic [1:0] vway;
  logic [1:0] w_mm;
  logic [1:0] sel_way;
  logic vdirty;

  // Address decode of the request
  assign set = cpu_addr[FWUC_IDX_MSB:FWUC_IDX_LSB];
  assign wd = cpu_addr[FWUC_WORD_MSB:FWUC_WORD_LSB];
  assign is_mm = cpu_addr[31:25] == FWUC_MM_WIN;
  assign is_tagw = !cpu_addr[FWUC_MM_SEL_BIT];
  assign mm_ok = is_mm && !cpu_fetch;
  assign cach = en_r && (!cpu_addr[31] || cpu_addr[31:29] == FWUC_P1 || cpu_addr[31:29] == FWUC_P3);
  assign wback = (cpu_addr[31:29] == FWUC_P1) ? cb_r : !wt_r;
  assign cmp_tag = is_mm ? cpu_wdata[FWUC_TAG_MSB:FWUC_TAG_LSB] : cpu_addr[FWUC_TAG_MSB:FWUC_TAG_LSB];

  // Parallel tag compare over the four ways
  for (genvar w = 0; w < 4; w++) begin : g_way
    assign hit_raw[w] = tag_r[{set, 2'(w)}] == cmp_tag;
    assign hits[w] = hit_raw[w] && val_r[{set, 2'(w)}];
  end

  // Way selection
  assign hit = |hits;
  assign hway = hits[3] ? 2'd3 : hits[2] ? 2'd2 : hits[1] ? 2'd1 : 2'd0;
  assign rway = hit_raw[3] ? 2'd3 : hit_raw[2] ? 2'd2 : hit_raw[1] ? 2'd1 : 2'd0;
  assign vway = fwuc_lru_victim(lru_r[set]);
  // Associative way only for tag writes; tag reads always use the way field
  assign w_mm = (is_tagw && cpu_we && cpu_addr[FWUC_ASSOC_BIT]) ? rway : cpu_addr[FWUC_WAY_MSB:FWUC_WAY_LSB];
  assign sel_way = is_mm ? w_mm : hway;
  assign vdirty = val_r[{set, vway}] && dty_r[{set, vway}];

  // ************************************************
  // Request classification
  // ************************************************
  logic take;
  logic fill_go;
  logic ext_go;
  logic wbhaz;
  logic stall;
  logic acc;
  logic go_bus;
  logic now_ack;
  logic main_ack;
  logic drn_ack;
  logic fill_last;
  logic mm_tag_wr;
  logic [31:0] tag_word;
  logic [31:0] rd_word;
  logic [31:0] fill_word;

  // Which path a new request takes
  assign take = st_r == S_IDLE && cpu_req && !cpu_ack;
  assign fill_go = cach && !hit && (!cpu_we || wback);
  assign ext_go = (cach && cpu_we && !wback) || (!cach && !is_mm);
  assign wbhaz = wb_valid_r && wb_addr_r[28:4] == cpu_addr[28:4];
  assign stall = (fill_go && vdirty && wb_valid_r) || ((fill_go || ext_go) && wbhaz);
  assign acc = take && !stall;
  assign go_bus = acc && (fill_go || ext_go);
  assign now_ack = acc && !fill_go && !ext_go;
  assign main_ack = mem_req && mem_ack && !own_drn_r;
  assign drn_ack = mem_req && mem_ack && own_drn_r;
  assign fill_last = st_r == S_FILL && main_ack && fcnt_r == 2'd3;
  assign mm_tag_wr = acc && mm_ok && is_tagw && cpu_we;

  // Read data sources
  assign tag_word = {3'b000, tag_r[{set, w_mm}], lru_r[set], 2'b00, dty_r[{set, w_mm}], val_r[{set, w_mm}]};
  assign rd_word = dat_r[{set, sel_way, wd}];
  assign fill_word = (rq_we_r && fcnt_r == rq_addr_r[3:2]) ? rq_wdata_r : mem_rdata;

  // ************************************************
  // Array write ports
  // ************************************************
  logic twe;
  logic [7:0] twidx;
  logic [18:0] twtag;
  logic dwe;
  logic [9:0] dwidx;
  logic [31:0] dwdat;
  logic vdwe;
  logic [7:0] vdidx;
  logic vnew;
  logic dnew;
  logic lwe;
  logic [5:0] lset;
  logic [5:0] lnew;
  logic infill;

  // Tag port
  assign infill = st_r == S_FILL;
  assign twe = fill_last || (mm_tag_wr && !cpu_addr[FWUC_ASSOC_BIT]);
  assign twidx = infill ? {rq_addr_r[9:4], f_way_r} : {set, w_mm};
  assign twtag = infill ? rq_addr_r[FWUC_TAG_MSB:FWUC_TAG_LSB] : cpu_wdata[FWUC_TAG_MSB:FWUC_TAG_LSB];

  // Data port: refill word, hit write, window write
  assign dwe = (infill && main_ack) || (acc && cpu_we && ((cach && hit) || (mm_ok && !is_tagw)));
  assign dwidx = infill ? {rq_addr_r[9:4], f_way_r, fcnt_r} : {set, sel_way, wd};
  assign dwdat = infill ? fill_word : cpu_wdata;

  // Valid and dirty port
  assign vdwe = twe || (mm_tag_wr && |hit_raw) || (acc && cach && hit && cpu_we && wback);
  assign vdidx = infill ? twidx : {set, sel_way};
  assign vnew = infill ? 1'b1 : is_mm ? cpu_wdata[FWUC_VAL_BIT] : 1'b1;
  assign dnew = infill ? rq_we_r : is_mm ? cpu_wdata[FWUC_DTY_BIT] : 1'b1;

  // LRU port
  assign lwe = fill_last || (acc && cach && hit) || (mm_tag_wr && !cpu_addr[FWUC_ASSOC_BIT]);
  assign lset = infill ? rq_addr_r[9:4] : set;
  assign lnew = infill ? fwuc_lru_touch(f_way_r, lru_r[lset]) :
                is_mm ? cpu_wdata[9:4] : fwuc_lru_touch(hway, lru_r[set]);

  // Tags and data carry no reset
  always_ff @(posedge pclk) begin
    if (twe) begin
      tag_r[twidx] <= twtag;
    end
    if (dwe) begin
      dat_r[dwidx] <= dwdat;
    end
  end

  // Line state; a same-cycle update wins over invalidate-all
  logic flush;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      val_r <= '0;
      dty_r <= '0;
      for (int i = 0; i < 64; i++) begin
        lru_r[i] <= 6'h00;
      end
    end else begin
      if (flush) begin
        val_r <= '0;
        dty_r <= '0;
        for (int i = 0; i < 64; i++) begin
          lru_r[i] <= 6'h00;
        end
      end
      if (vdwe) begin
        val_r[vdidx] <= vnew;
        dty_r[vdidx] <= dnew;
      end
      if (lwe) begin
        lru_r[lset] <= lnew;
      end
    end
  end

  // ************************************************
  // Control sequence
  // ************************************************
  // Request capture and state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= S_IDLE;
      rq_addr_r <= 32'h0000_0000;
      rq_we_r <= 1'b0;
      rq_wdata_r <= 32'h0000_0000;
      f_way_r <= 2'd0;
      fcnt_r <= 2'd0;
    end else begin
      unique case (st_r)
        S_IDLE: if (go_bus) begin
          rq_addr_r <= cpu_addr;
          rq_we_r <= cpu_we;
          rq_wdata_r <= cpu_wdata;
          f_way_r <= vway;
          fcnt_r <= 2'd0;
          st_r <= fill_go ? S_FILL : S_EXT;
        end
        S_FILL: if (main_ack) begin
          fcnt_r <= fcnt_r + 2'd1;
          st_r <= (fcnt_r == 2'd3) ? S_IDLE : S_FILL;
        end
        S_EXT: if (main_ack) begin
          st_r <= S_IDLE;
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end

  // CPU answer
  logic crit;
  assign crit = infill && main_ack && fcnt_r == rq_addr_r[3:2];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_ack <= 1'b0;
      cpu_err <= 1'b0;
      cpu_rdata <= 32'h0000_0000;
    end else begin
      cpu_ack <= now_ack || crit || (st_r == S_EXT && main_ack);
      cpu_err <= now_ack && is_mm && cpu_fetch;
      if (now_ack) begin
        cpu_rdata <= (is_mm && is_tagw) ? tag_word : rd_word;
      end else if (crit || (st_r == S_EXT && main_ack && !rq_we_r)) begin
        cpu_rdata <= mem_rdata;
      end
    end
  end

  // ************************************************
  // Write-back buffer and external bus
  // ************************************************
  logic iss_main;
  logic iss_drn;
  assign iss_main = !mem_req && (st_r == S_FILL || st_r == S_EXT);
  assign iss_drn = !mem_req && !iss_main && wb_valid_r && st_r == S_IDLE && !go_bus;

  // Victim capture and drain count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wb_valid_r <= 1'b0;
      wb_addr_r <= 32'h0000_0000;
      wcnt_r <= 2'd0;
      for (int i = 0; i < 4; i++) begin
        wbd_r[i] <= 32'h0000_0000;
      end
    end else if (go_bus && fill_go && vdirty) begin
      wb_valid_r <= 1'b1;
      wb_addr_r <= {3'b000, tag_r[{set, vway}], set, 4'h0};
      wcnt_r <= 2'd0;
      for (int i = 0; i < 4; i++) begin
        wbd_r[i] <= dat_r[{set, vway, 2'(i)}];
      end
    end else if (drn_ack) begin
      wcnt_r <= wcnt_r + 2'd1;
      wb_valid_r <= wcnt_r != 2'd3;
    end
  end

  // Bus request, refill ahead of drain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 32'h0000_0000;
      mem_wdata <= 32'h0000_0000;
      own_drn_r <= 1'b0;
    end else if (mem_req && mem_ack) begin
      mem_req <= 1'b0;
    end else if (iss_main) begin
      mem_req <= 1'b1;
      own_drn_r <= 1'b0;
      mem_we <= st_r == S_EXT && rq_we_r;
      mem_addr <= (st_r == S_FILL) ? {3'b000, rq_addr_r[28:4], fcnt_r, 2'b00} : rq_addr_r;
      mem_wdata <= rq_wdata_r;
    end else if (iss_drn) begin
      mem_req <= 1'b1;
      own_drn_r <= 1'b1;
      mem_we <= 1'b1;
      mem_addr <= {wb_addr_r[31:4], wcnt_r, 2'b00};
      mem_wdata <= wbd_r[wcnt_r];
    end
  end

  // ************************************************
  // APB registers
  // ************************************************
  logic apb_wr;
  logic sel_ctrl;
  logic sel_size;
  logic sel_stat;
  logic [31:0] rd_mux;
  assign apb_wr = psel && penable && pwrite;
  assign sel_ctrl = paddr == FWUC_CTRL_OFF;
  assign sel_size = paddr == FWUC_SIZE_OFF;
  assign sel_stat = paddr == FWUC_STAT_OFF;
  assign flush = apb_wr && sel_ctrl && pwdata[FWUC_FLUSH_BIT];
  assign rd_mux = sel_ctrl ? {29'h0, cb_r, wt_r, en_r} :
                  sel_size ? {15'h0, size_r, 14'h0} :
                  sel_stat ? {30'h0, st_r != S_IDLE, wb_valid_r} : 32'h0000_0000;

  // Control and size fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_r <= 1'b0;
      wt_r <= 1'b0;
      cb_r <= 1'b0;
      size_r <= FWUC_SIZE_RST;
    end else if (apb_wr && sel_ctrl) begin
      en_r <= pwdata[FWUC_EN_BIT];
      wt_r <= pwdata[FWUC_WT_BIT];
      cb_r <= pwdata[FWUC_CB_BIT];
    end else if (apb_wr && sel_size) begin
      size_r <= pwdata[FWUC_SIZE_MSB:FWUC_SIZE_LSB];
    end
  end

  // Zero-wait answer, data loaded in setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !(sel_ctrl || sel_size || sel_stat);
      prdata <= (psel && !penable && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end
endmodule

// ==== verif/fwuc_cache_asserts.sv ====
// Concurrent checks on the ports of the four-way cache.
// Assumes one pclk domain; bound onto fwuc_cache below.
`timescale 1ns/1ps
module fwuc_cache_chk import fwuc_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cpu_req,
  input wire logic cpu_we,
  input wire logic cpu_fetch,
  input wire logic [31:0] cpu_addr,
  input wire logic [31:0] cpu_wdata,
  input wire logic cpu_ack,
  input wire logic cpu_err,
  input wire logic [31:0] cpu_rdata,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata
);
  // ********
  // Checks
  // ********
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Steps of an APB read and of a bus wait
  sequence s_setup; psel && !penable; endsequence
  sequence s_answer; pready ##1 !pready; endsequence
  sequence s_wait; mem_req && !mem_ack; endsequence
  apb_answer_a: assert property (s_setup |=> s_answer)
    else $error("apb answer not one cycle");
  size_rsvd_a: assert property (pready && !pwrite && paddr == FWUC_SIZE_OFF |->
    prdata[31:17] == 15'h0 && prdata[13:0] == 14'h0) else $error("size reserved bits set");
  ctrl_flush_a: assert property (pready && !pwrite && paddr == FWUC_CTRL_OFF |->
    prdata[31:3] == 29'h0) else $error("flush or reserved bit reads one");
  fetch_err_a: assert property (cpu_ack && cpu_req |->
    cpu_err == (cpu_fetch && cpu_addr[31:25] == FWUC_MM_WIN)) else $error("window fetch error wrong");
  bus_hold_a: assert property (s_wait |=> mem_req && $stable(mem_addr) &&
    $stable(mem_we) && $stable(mem_wdata)) else $error("bus request changed early");
  bus_drop_a: assert property (mem_ack |=> !mem_req)
    else $error("bus request held after ack");
  ack_pulse_a: assert property (cpu_ack |=> !cpu_ack)
    else $error("cpu ack longer than a cycle");
  bypass_rd_a: assert property (cpu_ack && cpu_req && !cpu_we && cpu_addr[31:29] == 3'b101 |->
    $past(mem_ack) && cpu_rdata == $past(mem_rdata)) else $error("uncached read not from bus");
endmodule

bind fwuc_cache fwuc_cache_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .cpu_req, .cpu_we, .cpu_fetch, .cpu_addr, .cpu_wdata, .cpu_ack,
  .cpu_err, .cpu_rdata, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);

// ==== verif/fwuc_mem_model.sv ====
// External memory behind the cache bus, prompt or slow.
// Assumes requests held until ack; unwritten words read as inverted address.
`timescale 1ns/1ps
module fwuc_mem_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [31:0] mem [logic [31:0]];
  logic [31:0] wa, wd;
  int n_rd, n_wr, cnt;
  // ********
  // Responder
  // ********
  // Ack after 0 or 3 wait cycles, log writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      mem_rdata <= 32'h0;
      cnt <= 0;
      n_rd <= 0;
      n_wr <= 0;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata; // Data line moves outside acks
      if (mem_req && !mem_ack) begin
        if (cnt < (slow ? 3 : 0)) begin
          cnt <= cnt + 1;
        end else begin
          cnt <= 0;
          mem_ack <= 1'b1;
          if (mem_we) begin
            mem[mem_addr] = mem_wdata;
            wa <= mem_addr;
            wd <= mem_wdata;
            n_wr <= n_wr + 1;
          end else begin
            mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : ~mem_addr;
            n_rd <= n_rd + 1;
          end
        end
      end
    end
  end
endmodule

// ==== verif/testbench.sv ====
// Self-checking bench for the cache: APB registers and CPU accesses.
// Assumes fwuc_mem_model on the bus side and the bound checker.
`timescale 1ns/1ps
module testbench import fwuc_pkg::*;;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
  logic cpu_req = 1'b0, cpu_we = 1'b0, cpu_fetch = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, cpu_addr = 32'h0, cpu_wdata = 32'h0;
  logic [31:0] prdata, cpu_rdata, mem_addr, mem_wdata, mem_rdata, rd;
  logic pready, pslverr, cpu_ack, cpu_err, mem_req, mem_we, mem_ack, er;
  int n_errors = 0, comparisons = 0, w0, i;

  fwuc_cache DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .cpu_req, .cpu_we, .cpu_fetch, .cpu_addr, .cpu_wdata, .cpu_ack, .cpu_err, .cpu_rdata,
    .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);
  fwuc_mem_model mm (.pclk, .presetn, .slow, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack,
    .mem_rdata);

  // ********
  // Tasks
  // ********
  always #5 pclk = ~pclk;

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  // APB transfer held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) chk(1'b0, 1'b1);
  endtask

  // CPU request held until cpu_ack
  task automatic cpu(input logic w, input logic f, input logic [31:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    cpu_req <= 1'b1;
    cpu_we <= w;
    cpu_fetch <= f;
    cpu_addr <= a;
    cpu_wdata <= d;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (cpu_ack !== 1'b1 && k < 500);
    rd = cpu_rdata;
    er = cpu_err;
    cpu_req <= 1'b0;
    if (k >= 500) chk(1'b0, 1'b1);
  endtask

  task automatic ar(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(rd, x);
  endtask

  task automatic cr(input logic [31:0] a, input logic [31:0] x);
    cpu(1'b0, 1'b0, a, 32'h0);
    chk(rd, x);
  endtask

  task give_verdict;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ********
  // Tests
  // ********
  initial begin
    #100000;
    n_errors++;
    give_verdict;
  end

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    ar(FWUC_SIZE_OFF, 32'h0000_4000);
    ar(FWUC_CTRL_OFF, 32'h0);
    apb(1'b1, FWUC_SIZE_OFF, 32'hffff_ffff);
    ar(FWUC_SIZE_OFF, 32'h0001_c000);
    apb(1'b1, FWUC_SIZE_OFF, 32'h0001_0000);
    ar(FWUC_SIZE_OFF, 32'h0001_0000);
    ar(12'h00c, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, FWUC_CTRL_OFF, 32'h5);
    w0 = mm.n_rd;
    cr(32'h8000_0018, ~32'h0000_0018);
    cr(32'hf000_0c10, 32'h0000_00b1);
    cr(32'h8000_0010, ~32'h0000_0010);
    chk(mm.n_rd - w0, 4);
    w0 = mm.n_wr;
    cpu(1'b1, 1'b0, 32'h8000_0014, 32'hcafe_0001);
    cr(32'hf000_0c10, 32'h0000_00b3);
    chk(mm.n_wr - w0, 0);
    slow <= 1'b1;
    for (int k = 1; k < 5; k++) cr(32'h8000_0010 | (k << 10), ~(32'h0000_0010 | (k << 10)));
    i = 0;
    do begin
      apb(1'b0, FWUC_STAT_OFF, 32'h0);
      i++;
    end while (rd[0] !== 1'b0 && i < 100);
    chk(mm.n_wr - w0, 4);
    chk(mm.wa, 32'h0000_001c);
    chk(mm.wd, ~32'h0000_001c);
    cr(32'hf000_0c10, 32'h0000_10b1);
    cpu(1'b1, 1'b0, 32'h8000_2024, 32'h0bad_0002);
    cr(32'hf000_0c20, 32'h0000_20b3);
    cr(32'h8000_2024, 32'h0bad_0002);
    slow <= 1'b0;
    apb(1'b1, FWUC_CTRL_OFF, 32'h3);
    w0 = mm.n_wr;
    cpu(1'b1, 1'b0, 32'h0000_3010, 32'h1111_2222);
    chk(mm.wa, 32'h0000_3010);
    cr(32'hf000_0810, 32'h0000_04b1);
    cr(32'h0000_3030, ~32'h0000_3030);
    cpu(1'b1, 1'b0, 32'h0000_3030, 32'h1234_5678);
    chk(mm.n_wr - w0, 2);
    cr(32'hf000_0c30, 32'h0000_30b1);
    cr(32'h0000_3030, 32'h1234_5678);
    cpu(1'b1, 1'b0, 32'hf000_0038, 32'h0000_3000);
    cr(32'hf000_0c30, 32'h0000_30b0);
    cpu(1'b1, 1'b0, 32'hf000_0430, 32'h0000_1401);
    cr(32'hf000_0430, 32'h0000_1401);
    cr(32'hf000_0438, 32'h0000_1401);
    w0 = mm.n_rd;
    cr(32'ha000_0040, ~32'ha000_0040);
    chk(mm.n_rd - w0, 1);
    cpu(1'b0, 1'b1, 32'hf000_0c10, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, FWUC_CTRL_OFF, 32'hb);
    ar(FWUC_CTRL_OFF, 32'h3);
    cr(32'hf000_0430, 32'h0000_1400);
    cr(32'hf000_0c20, 32'h0000_2000);
    give_verdict;
  end
endmodule
